/* File: veq_defs.svh */
// Offsets, field positions, reset values and timing for the pin control block
// Assumes a 250 MHz system clock and a 32-bit APB register bus
`ifndef VEQ_DEFS_SVH
`define VEQ_DEFS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define VEQ_ADDR_W 8
`define VEQ_OFS_CTRL 8'h00
`define VEQ_OFS_STATUS 8'h04
`define VEQ_OFS_IRQ_STAT 8'h08
`define VEQ_OFS_IRQ_MASK 8'h0C

// ----------------------------------------
// Control fields
// ----------------------------------------
`define VEQ_CTRL_COLOR_OVR 0
`define VEQ_CTRL_POL_OVR 1
`define VEQ_CTRL_STANDALONE 2
`define VEQ_CTRL_REACQ 3
`define VEQ_CTRL_RESET 3'h4

// ----------------------------------------
// Status fields
// ----------------------------------------
`define VEQ_ST_LOCK 0
`define VEQ_ST_COLOR 1
`define VEQ_ST_INVERT 2
`define VEQ_ST_FREEZE 3
`define VEQ_ST_EQ_OFF 4
`define VEQ_ST_STATE_LO 5

// ----------------------------------------
// Interrupt fields
// ----------------------------------------
`define VEQ_IRQ_W 4
`define VEQ_IRQ_LOCK_GAIN 0
`define VEQ_IRQ_LOCK_LOSS 1
`define VEQ_IRQ_REACQ 2
`define VEQ_IRQ_POL_CHG 3
`define VEQ_IRQ_MASK_RESET 4'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define VEQ_CLK_MHZ 250
`define VEQ_SETTLE_US 10
`define VEQ_TOGGLE_WIN_US 1000
`define VEQ_ECHO_HOLDOFF 3

`endif

/* File: veq_pkg.sv */
// Types shared by the pin control block
// Assumes nothing beyond a SystemVerilog compiler
package veq_pkg;

  typedef enum logic [1:0]
  {
    VEQ_DISABLED,
    VEQ_ACQUIRE,
    VEQ_SETTLE,
    VEQ_LOCK_STATUS
  } veq_state_t;

  typedef logic [31:0] veq_word_t;

endpackage

/* File: veq_sync_if.sv */
// Raw and synchronised control levels between the top and its synchroniser
// Assumes both ends run on the same clock
`timescale 1ns/1ps

interface veq_sync_if #(parameter int W = 4);
  logic [W-1:0] raw;
  logic [W-1:0] sync;
  modport src (output raw, input sync);
  modport sink (input raw, output sync);
endinterface

/* File: veq_sync.sv */
// Two-stage synchroniser for a bundle of control levels
// Assumes levels that change slowly against the clock
`timescale 1ns/1ps

module veq_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  veq_sync_if.sink port
);

  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  // First stage feeds only the second stage
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_r <= '0;
      sync_r <= '0;
    end
    else if (ce)
    begin
      meta_r <= port.raw;
      sync_r <= meta_r;
    end
  end

  assign port.sync = sync_r;

endmodule // veq_sync

/* File: veq_ctrl.sv */
// Digital control and status pin logic around an adaptive cable equalizer
// Assumes a 250 MHz clock, an APB master, and analog status on plain inputs
//
// Summary of operation
// - Disable input low runs, high disables equalizer
// - Burst pin shows 1 colour, 0 monochrome
// - Driven burst pin forces colour or monochrome
// - Undriven burst and polarity pins show status
// - Polarity pin shows 0 nominal, 1 inverted
// - Driven polarity pin decides signal inversion
// - Stand-alone polarity pin double toggle reacquires
// - Lock high only when equalized and settled, or when frozen after lock with the signal present
// - Freeze high holds equalizer state unchanged, except in a cycle where a reacquire is issued
//
// Implementation choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "veq_defs.svh"

module veq_ctrl #(
  parameter int TOGGLE_WIN_CYC = `VEQ_TOGGLE_WIN_US * `VEQ_CLK_MHZ
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic CLK_EN_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [31:0] PADDR_IN,
  input wire veq_pkg::veq_word_t PWDATA_IN,
  output veq_pkg::veq_word_t PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  output logic IRQ_OUT,
  input wire logic EQUALIZER_OFF_IN,
  input wire logic FREEZE_IN,
  input wire logic COLOR_PIN_IN,
  output logic COLOR_PIN_OUT,
  output logic COLOR_PIN_OE_OUT,
  input wire logic POL_PIN_IN,
  output logic POL_PIN_OUT,
  output logic POL_PIN_OE_OUT,
  output logic LOCK_STATUS_OUT,
  input wire logic SIG_PRESENT_IN,
  input wire logic EQ_SETTLED_IN,
  input wire logic BURST_DET_IN,
  input wire logic INVERT_DET_IN,
  output logic EQ_ENABLE_OUT,
  output logic EQ_HOLD_OUT,
  output logic EQ_REACQ_OUT,
  output logic COLOR_MODE_OUT,
  output logic INVERT_PATH_OUT
);
  import veq_pkg::*;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int SETTLE_CYC = `VEQ_SETTLE_US * `VEQ_CLK_MHZ;
  localparam int SET_W = $clog2(SETTLE_CYC + 1);
  localparam int WIN_W = $clog2(TOGGLE_WIN_CYC + 1);

  // ----------------------------------------
  // Input synchronisers
  // ----------------------------------------
  veq_sync_if #(.W(4)) sync_bus ();

  assign sync_bus.raw = {POL_PIN_IN, COLOR_PIN_IN, FREEZE_IN,
                         EQUALIZER_OFF_IN};

  veq_sync #(
    .W(4)
  ) u_sync (
    .clk(CLK_IN),
    .rst(SYS_RST_IN),
    .ce(CLK_EN_IN),
    .port(sync_bus.sink)
  );

  logic eq_off_s;
  logic freeze_s;
  logic color_s;
  logic pol_s;

  assign eq_off_s = sync_bus.sync[0];
  assign freeze_s = sync_bus.sync[1];
  assign color_s = sync_bus.sync[2];
  assign pol_s = sync_bus.sync[3];

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  logic [2:0] ctrl_r;
  logic [`VEQ_IRQ_W-1:0] irq_stat_r;
  logic [`VEQ_IRQ_W-1:0] irq_mask_r;
  logic [`VEQ_IRQ_W-1:0] irq_event;
  veq_state_t state_r;
  veq_state_t state_nxt;
  logic [SET_W-1:0] settle_cnt_r;
  logic lock_r;
  logic sw_reacq;
  logic pin_reacq;
  logic reacq;
  logic color_ovr;
  logic pol_ovr;
  logic standalone;

  assign color_ovr = ctrl_r[`VEQ_CTRL_COLOR_OVR];
  assign pol_ovr = ctrl_r[`VEQ_CTRL_POL_OVR];
  assign standalone = ctrl_r[`VEQ_CTRL_STANDALONE];

  // ----------------------------------------
  // APB slave
  // ----------------------------------------
  logic [`VEQ_ADDR_W-1:0] addr;
  logic access;
  logic done;
  logic wr_done;
  logic rd_done;
  logic mapped;
  veq_word_t rd_mux;

  assign addr = PADDR_IN[`VEQ_ADDR_W-1:0];
  assign access = PSEL_IN && PENABLE_IN;
  assign done = access && PREADY_OUT;
  assign wr_done = done && PWRITE_IN && !PSLVERR_OUT;
  assign rd_done = done && !PWRITE_IN && !PSLVERR_OUT;
  assign mapped = (PADDR_IN[31:`VEQ_ADDR_W] == '0) &&
                  ((addr == `VEQ_OFS_CTRL) ||
                   (addr == `VEQ_OFS_STATUS) ||
                   (addr == `VEQ_OFS_IRQ_STAT) ||
                   (addr == `VEQ_OFS_IRQ_MASK));

  always_comb
  begin
    rd_mux = '0;
    case (addr)
      `VEQ_OFS_CTRL:
      begin
        rd_mux[2:0] = ctrl_r;
      end
      `VEQ_OFS_STATUS:
      begin
        rd_mux[`VEQ_ST_LOCK] = lock_r;
        rd_mux[`VEQ_ST_COLOR] = COLOR_MODE_OUT;
        rd_mux[`VEQ_ST_INVERT] = INVERT_PATH_OUT;
        rd_mux[`VEQ_ST_FREEZE] = freeze_s;
        rd_mux[`VEQ_ST_EQ_OFF] = eq_off_s;
        rd_mux[`VEQ_ST_STATE_LO +: 2] = state_r;
      end
      `VEQ_OFS_IRQ_STAT:
      begin
        rd_mux[`VEQ_IRQ_W-1:0] = irq_stat_r;
      end
      `VEQ_OFS_IRQ_MASK:
      begin
        rd_mux[`VEQ_IRQ_W-1:0] = irq_mask_r;
      end
      default:
      begin
        rd_mux = '0;
      end
    endcase
  end

  // One wait state: ready is raised in the second access cycle
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      PREADY_OUT <= 1'b0;
      PSLVERR_OUT <= 1'b0;
      PRDATA_OUT <= '0;
    end
    else if (CLK_EN_IN)
    begin
      if (access && !PREADY_OUT)
      begin
        PREADY_OUT <= 1'b1;
        PSLVERR_OUT <= !mapped;
        PRDATA_OUT <= mapped && !PWRITE_IN ? rd_mux : '0;
      end
      else
      begin
        PREADY_OUT <= 1'b0;
        PSLVERR_OUT <= 1'b0;
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      ctrl_r <= `VEQ_CTRL_RESET;
    end
    else if (CLK_EN_IN && wr_done && addr == `VEQ_OFS_CTRL)
    begin
      ctrl_r <= PWDATA_IN[2:0];
    end
  end

  // Reacquire bit is write-one, it never stores
  assign sw_reacq = wr_done && addr == `VEQ_OFS_CTRL &&
                    PWDATA_IN[`VEQ_CTRL_REACQ];

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      irq_mask_r <= `VEQ_IRQ_MASK_RESET;
    end
    else if (CLK_EN_IN && wr_done && addr == `VEQ_OFS_IRQ_MASK)
    begin
      irq_mask_r <= PWDATA_IN[`VEQ_IRQ_W-1:0];
    end
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  // Read clears only the bits it returned, so a late event is not lost
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      irq_stat_r <= '0;
    end
    else if (CLK_EN_IN)
    begin
      if (rd_done && addr == `VEQ_OFS_IRQ_STAT)
      begin
        irq_stat_r <= (irq_stat_r & ~PRDATA_OUT[`VEQ_IRQ_W-1:0]) | irq_event;
      end
      else
      begin
        irq_stat_r <= irq_stat_r | irq_event;
      end
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      IRQ_OUT <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      IRQ_OUT <= |((irq_stat_r | irq_event) & irq_mask_r);
    end
  end

  // ----------------------------------------
  // Polarity pin toggle detector
  // ----------------------------------------
  // Own drive echoes back on the pin; edges right after it are ignored
  logic pol_prev_r;
  logic [1:0] echo_cnt_r;
  logic [WIN_W-1:0] win_cnt_r;
  logic first_edge_r;
  logic pol_edge;

  assign pol_edge = (pol_s != pol_prev_r) && (echo_cnt_r == 2'h0);
  assign pin_reacq = standalone && pol_edge && first_edge_r;

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      pol_prev_r <= 1'b0;
      echo_cnt_r <= 2'h0;
    end
    else if (CLK_EN_IN)
    begin
      pol_prev_r <= pol_s;
      if (POL_PIN_OE_OUT && POL_PIN_OUT != INVERT_DET_IN)
      begin
        echo_cnt_r <= 2'(`VEQ_ECHO_HOLDOFF);
      end
      else if (echo_cnt_r != 2'h0)
      begin
        echo_cnt_r <= echo_cnt_r - 2'h1;
      end
    end
  end

  // Second edge inside the window completes a double toggle
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      first_edge_r <= 1'b0;
      win_cnt_r <= '0;
    end
    else if (CLK_EN_IN)
    begin
      if (!standalone || pin_reacq)
      begin
        first_edge_r <= 1'b0;
        win_cnt_r <= '0;
      end
      else if (pol_edge)
      begin
        first_edge_r <= 1'b1;
        win_cnt_r <= WIN_W'(TOGGLE_WIN_CYC);
      end
      else if (first_edge_r)
      begin
        win_cnt_r <= win_cnt_r - 1'b1;
        if (win_cnt_r == WIN_W'(1))
        begin
          first_edge_r <= 1'b0;
        end
      end
    end
  end

  assign reacq = sw_reacq || pin_reacq;

  // ----------------------------------------
  // Acquisition state machine
  // ----------------------------------------
  always_comb
  begin
    state_nxt = state_r;
    case (state_r)
      VEQ_DISABLED:
      begin
        if (!eq_off_s)
        begin
          state_nxt = VEQ_ACQUIRE;
        end
      end
      VEQ_ACQUIRE:
      begin
        if (SIG_PRESENT_IN && EQ_SETTLED_IN)
        begin
          state_nxt = VEQ_SETTLE;
        end
      end
      VEQ_SETTLE:
      begin
        if (!SIG_PRESENT_IN || !EQ_SETTLED_IN)
        begin
          state_nxt = VEQ_ACQUIRE;
        end
        else if (settle_cnt_r == SET_W'(SETTLE_CYC - 1))
        begin
          state_nxt = VEQ_LOCK_STATUS;
        end
      end
      VEQ_LOCK_STATUS:
      begin
        // Frozen loop keeps its lock while the signal stays present
        if (!SIG_PRESENT_IN || (!EQ_SETTLED_IN && !freeze_s))
        begin
          state_nxt = VEQ_ACQUIRE;
        end
      end
      default:
      begin
        state_nxt = VEQ_ACQUIRE;
      end
    endcase
    if (eq_off_s)
    begin
      state_nxt = VEQ_DISABLED;
    end
    else if (reacq)
    begin
      state_nxt = VEQ_ACQUIRE;
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      state_r <= VEQ_ACQUIRE;
    end
    else if (CLK_EN_IN)
    begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      settle_cnt_r <= '0;
    end
    else if (CLK_EN_IN)
    begin
      if (state_r == VEQ_SETTLE && state_nxt == VEQ_SETTLE)
      begin
        settle_cnt_r <= settle_cnt_r + 1'b1;
      end
      else
      begin
        settle_cnt_r <= '0;
      end
    end
  end

  // ----------------------------------------
  // Analog controls and status pins
  // ----------------------------------------
  logic lock_nxt;

  assign lock_nxt = state_nxt == VEQ_LOCK_STATUS && SIG_PRESENT_IN;

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      lock_r <= 1'b0;
      LOCK_STATUS_OUT <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      lock_r <= lock_nxt;
      LOCK_STATUS_OUT <= lock_nxt;
    end
  end

  // Lock and burst status are only as good as the detectors; the loop
  // itself never waits on them
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      EQ_ENABLE_OUT <= 1'b0;
      EQ_HOLD_OUT <= 1'b0;
      EQ_REACQ_OUT <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      EQ_ENABLE_OUT <= !eq_off_s;
      EQ_HOLD_OUT <= freeze_s && !reacq;
      EQ_REACQ_OUT <= reacq && !eq_off_s;
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      COLOR_MODE_OUT <= 1'b0;
      INVERT_PATH_OUT <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      COLOR_MODE_OUT <= color_ovr ? color_s : BURST_DET_IN;
      INVERT_PATH_OUT <= pol_ovr ? pol_s : INVERT_DET_IN;
    end
  end

  // Each pin is released while its override bit in the control register is set
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      COLOR_PIN_OUT <= 1'b0;
      COLOR_PIN_OE_OUT <= 1'b0;
      POL_PIN_OUT <= 1'b0;
      POL_PIN_OE_OUT <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      COLOR_PIN_OUT <= BURST_DET_IN;
      COLOR_PIN_OE_OUT <= !color_ovr;
      POL_PIN_OUT <= INVERT_DET_IN;
      POL_PIN_OE_OUT <= !pol_ovr;
    end
  end

  // ----------------------------------------
  // Event capture
  // ----------------------------------------
  logic inv_prev_r;

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN)
  begin
    if (SYS_RST_IN)
    begin
      inv_prev_r <= 1'b0;
    end
    else if (CLK_EN_IN)
    begin
      inv_prev_r <= INVERT_PATH_OUT;
    end
  end

  always_comb
  begin
    irq_event = '0;
    irq_event[`VEQ_IRQ_LOCK_GAIN] = lock_nxt && !lock_r;
    irq_event[`VEQ_IRQ_LOCK_LOSS] = !lock_nxt && lock_r;
    irq_event[`VEQ_IRQ_REACQ] = reacq;
    irq_event[`VEQ_IRQ_POL_CHG] = INVERT_PATH_OUT != inv_prev_r;
  end

endmodule // veq_ctrl

/* File: veq_ctrl_props.sv */
// Checker of the pin control block, bound into its top module
// Assumes attempts that see the clock enable low are dropped
`timescale 1ns/1ps

module veq_ctrl_props #(
  parameter int TOGGLE_WIN_CYC = 250000
) (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic CLK_EN_IN,
  input wire logic EQUALIZER_OFF_IN,
  input wire logic FREEZE_IN,
  input wire logic COLOR_PIN_IN,
  input wire logic COLOR_PIN_OUT,
  input wire logic COLOR_PIN_OE_OUT,
  input wire logic POL_PIN_IN,
  input wire logic POL_PIN_OE_OUT,
  input wire logic LOCK_STATUS_OUT,
  input wire logic SIG_PRESENT_IN,
  input wire logic BURST_DET_IN,
  input wire logic EQ_ENABLE_OUT,
  input wire logic EQ_HOLD_OUT,
  input wire logic EQ_REACQ_OUT,
  input wire logic COLOR_MODE_OUT,
  input wire logic INVERT_PATH_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  // Frozen cycles stall the pipeline, so such attempts are dropped
  default disable iff (SYS_RST_IN || !CLK_EN_IN);

  // Two sync flops plus output flop, so four steady samples suffice
  AST_EQ_ON:
    assert property ((!EQUALIZER_OFF_IN)[*4] |-> EQ_ENABLE_OUT)
    else $error("equalizer not enabled");
  AST_EQ_OFF:
    assert property (EQUALIZER_OFF_IN[*4] |-> !EQ_ENABLE_OUT)
    else $error("equalizer not disabled");
  AST_HOLD:
    assert property (FREEZE_IN[*4] ##0 !EQ_REACQ_OUT |-> EQ_HOLD_OUT)
    else $error("freeze not applied");
  AST_BURST:
    assert property (BURST_DET_IN[*4] ##0 COLOR_PIN_OE_OUT |-> COLOR_PIN_OUT)
    else $error("burst pin not showing colour");
  AST_COLOR_OVR:
    assert property ((!COLOR_PIN_OE_OUT && COLOR_PIN_IN)[*4] |->
                     COLOR_MODE_OUT)
    else $error("colour override ignored");
  AST_INV_OVR:
    assert property ((!POL_PIN_OE_OUT && !POL_PIN_IN)[*4] |-> !INVERT_PATH_OUT)
    else $error("polarity override ignored");
  AST_LOCK_SIG:
    assert property ((!SIG_PRESENT_IN)[*3] |-> !LOCK_STATUS_OUT)
    else $error("lock without signal");
  AST_REACQ_DROP:
    assert property (EQ_REACQ_OUT |-> ##[1:2] !LOCK_STATUS_OUT)
    else $error("lock kept over reacquire");

  cover property ($rose(LOCK_STATUS_OUT));
  cover property (EQ_REACQ_OUT);
  cover property (FREEZE_IN && EQ_HOLD_OUT);
endmodule // veq_ctrl_props

bind veq_ctrl veq_ctrl_props #(.TOGGLE_WIN_CYC(TOGGLE_WIN_CYC))
  u_veq_ctrl_props (
  .CLK_IN, .SYS_RST_IN, .CLK_EN_IN, .EQUALIZER_OFF_IN, .FREEZE_IN,
  .COLOR_PIN_IN,
  .COLOR_PIN_OUT, .COLOR_PIN_OE_OUT, .POL_PIN_IN, .POL_PIN_OE_OUT,
  .LOCK_STATUS_OUT, .SIG_PRESENT_IN, .BURST_DET_IN, .EQ_ENABLE_OUT,
  .EQ_HOLD_OUT, .EQ_REACQ_OUT, .COLOR_MODE_OUT, .INVERT_PATH_OUT
);

/* File: veq_board_model.sv */
// Board-side model: strapping and controller on the control pins
// Assumes the bench sets the board levels after a clock edge
`timescale 1ns/1ps

module veq_board_model (
  input wire logic lock_in,
  input wire logic color_oe_in,
  input wire logic color_dev_in,
  input wire logic pol_oe_in,
  input wire logic pol_dev_in,
  output logic eq_off_out,
  output logic freeze_out,
  output logic color_pin_out,
  output logic pol_pin_out
);
  logic eq_off_r = 1'b0;
  logic freeze_r = 1'b0;
  logic color_r = 1'b0;
  logic pol_r = 1'b0;
  logic lock_follow_r = 1'b0;

  // Firm level on the disable pin, never left floating
  assign eq_off_out = eq_off_r;
  // Lock looped to freeze on request, else freeze_r
  assign freeze_out = lock_follow_r ? lock_in : freeze_r;
  // Board drives a pin only once the device lets go
  assign color_pin_out = color_oe_in ? color_dev_in : color_r;
  assign pol_pin_out = pol_oe_in ? pol_dev_in : pol_r;
endmodule // veq_board_model

/* File: tb_veq_ctrl.sv */
// Bench for the pin control block: APB master, status inputs, board
// Assumes package, design, checker and board model compile first
`timescale 1ns/1ps

module tb_veq_ctrl;
  import veq_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, erv;
  logic [31:0] pa = 32'h0;
  veq_word_t pwd = 32'h0, prd, rdv;
  logic sig = 1'b0, stl = 1'b0, bst = 1'b0, inv = 1'b0;
  logic prdy, perr, irq, eqoff, frz, cin, cout, coe, pin, pout, poe;
  logic lck, een, hld, rq, cmd, ipath;
  logic ce = 1'b1;
  int miscompares = 0, n_checks = 0, cycles = 0;

  veq_ctrl #(.TOGGLE_WIN_CYC(20)) u_veq_ctrl (
    .CLK_IN(clk), .SYS_RST_IN(rst), .CLK_EN_IN(ce), .PSEL_IN(psel),
    .PENABLE_IN(pen), .PWRITE_IN(pwr), .PADDR_IN(pa), .PWDATA_IN(pwd),
    .PRDATA_OUT(prd), .PREADY_OUT(prdy), .PSLVERR_OUT(perr), .IRQ_OUT(irq),
    .EQUALIZER_OFF_IN(eqoff), .FREEZE_IN(frz), .COLOR_PIN_IN(cin),
    .COLOR_PIN_OUT(cout), .COLOR_PIN_OE_OUT(coe), .POL_PIN_IN(pin),
    .POL_PIN_OUT(pout), .POL_PIN_OE_OUT(poe), .LOCK_STATUS_OUT(lck),
    .SIG_PRESENT_IN(sig), .EQ_SETTLED_IN(stl), .BURST_DET_IN(bst),
    .INVERT_DET_IN(inv), .EQ_ENABLE_OUT(een), .EQ_HOLD_OUT(hld),
    .EQ_REACQ_OUT(rq), .COLOR_MODE_OUT(cmd), .INVERT_PATH_OUT(ipath)
  );
  veq_board_model u_veq_board_model (
    .lock_in(lck), .color_oe_in(coe), .color_dev_in(cout),
    .pol_oe_in(poe), .pol_dev_in(pout), .eq_off_out(eqoff),
    .freeze_out(frz), .color_pin_out(cin), .pol_pin_out(pin)
  );

  always #2 clk = ~clk;

  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hang guard: run needs about 2700 cycles
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 8000)
    begin
      miscompares = miscompares + 1;
      finish_test();
    end
  end

  task chk(input veq_word_t got, input veq_word_t exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic apb(input logic w, input logic [31:0] a,
    input veq_word_t d, output veq_word_t r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    pa <= a;
    pwd <= d;
    @(posedge clk);
    pen <= 1'b1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (prdy !== 1'b1);
    chk(n, 32'h2);
    r = prd;
    e = perr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task t_reset;
    apb(1'b0, 32'h0, 32'h0, rdv, erv);
    chk(rdv, 32'h4);
    apb(1'b0, 32'hC, 32'h0, rdv, erv);
    chk(rdv, 32'h0);
    chk(coe, 1'b1);
    chk(poe, 1'b1);
    apb(1'b0, 32'h14, 32'h0, rdv, erv);
    chk({rdv[30:0], erv}, 32'h1);
    $display("reset test done");
  endtask

  task t_eqoff;
    @(posedge clk);
    u_veq_board_model.eq_off_r <= 1'b1;
    cyc(2);
    chk(een, 1'b1);
    cyc(1);
    chk(een, 1'b0);
    @(posedge clk);
    u_veq_board_model.eq_off_r <= 1'b0;
    cyc(4);
    chk(een, 1'b1);
    $display("disable test done");
  endtask

  task t_clken;
    @(posedge clk);
    ce <= 1'b0;
    u_veq_board_model.eq_off_r <= 1'b1;
    cyc(6);
    chk(een, 1'b1);
    @(posedge clk);
    ce <= 1'b1;
    cyc(3);
    chk(een, 1'b0);
    @(posedge clk);
    u_veq_board_model.eq_off_r <= 1'b0;
    cyc(4);
    chk(een, 1'b1);
    $display("clock enable test done");
  endtask

  task t_color;
    @(posedge clk);
    bst <= 1'b1;
    cyc(4);
    chk({cout, cmd}, 32'h3);
    @(posedge clk);
    bst <= 1'b0;
    cyc(4);
    chk(cout, 1'b0);
    apb(1'b1, 32'h0, 32'h5, rdv, erv);
    @(posedge clk);
    u_veq_board_model.color_r <= 1'b1;
    cyc(5);
    chk({coe, cmd}, 32'h1);
    @(posedge clk);
    u_veq_board_model.color_r <= 1'b0;
    cyc(4);
    chk(cmd, 1'b0);
    $display("colour test done");
  endtask

  task t_pol;
    @(posedge clk);
    inv <= 1'b1;
    cyc(4);
    chk({pout, ipath}, 32'h3);
    @(posedge clk);
    inv <= 1'b0;
    cyc(4);
    chk(pout, 1'b0);
    apb(1'b1, 32'h0, 32'h6, rdv, erv);
    @(posedge clk);
    u_veq_board_model.pol_r <= 1'b1;
    cyc(5);
    chk({coe, poe, ipath}, 32'h5);
    $display("polarity test done");
  endtask

  task t_lock;
    int n;
    n = 0;
    @(posedge clk);
    sig <= 1'b1;
    stl <= 1'b1;
    while (lck !== 1'b1 && n < 3000)
    begin
      @(posedge clk);
      n++;
    end
    #1;
    chk(n >= 2500 && n < 2520, 1'b1);
    chk(irq, 1'b0);
    apb(1'b0, 32'h4, 32'h0, rdv, erv);
    chk(rdv, 32'h65);
    apb(1'b1, 32'hC, 32'hF, rdv, erv);
    cyc(2);
    chk(irq, 1'b1);
    apb(1'b0, 32'h8, 32'h0, rdv, erv);
    chk(rdv[0], 1'b1);
    cyc(2);
    chk(irq, 1'b0);
    @(posedge clk);
    u_veq_board_model.freeze_r <= 1'b1;
    cyc(4);
    chk(hld, 1'b1);
    @(posedge clk);
    stl <= 1'b0;
    cyc(4);
    chk(lck, 1'b1);
    @(posedge clk);
    stl <= 1'b1;
    u_veq_board_model.freeze_r <= 1'b0;
    cyc(4);
    chk(hld, 1'b0);
    @(posedge clk);
    u_veq_board_model.lock_follow_r <= 1'b1;
    cyc(4);
    chk(hld, 1'b1);
    @(posedge clk);
    u_veq_board_model.lock_follow_r <= 1'b0;
    cyc(4);
    chk(hld, 1'b0);
    $display("lock test done");
  endtask

  task t_reacq;
    int n;
    n = 0;
    @(posedge clk);
    u_veq_board_model.pol_r <= 1'b0;
    cyc(4);
    chk(ipath, 1'b0);
    @(posedge clk);
    u_veq_board_model.pol_r <= 1'b1;
    while (rq !== 1'b1 && n < 12)
    begin
      @(posedge clk);
      n++;
    end
    chk(n < 12, 1'b1);
    cyc(2);
    chk(lck, 1'b0);
    apb(1'b0, 32'h8, 32'h0, rdv, erv);
    chk(rdv[2], 1'b1);
    apb(1'b1, 32'h0, 32'h2, rdv, erv);
    cyc(20);
    @(posedge clk);
    u_veq_board_model.pol_r <= 1'b0;
    cyc(4);
    @(posedge clk);
    u_veq_board_model.pol_r <= 1'b1;
    n = 0;
    repeat (12)
    begin
      @(posedge clk);
      if (rq === 1'b1)
        n++;
    end
    chk(n, 0);
    apb(1'b1, 32'h0, 32'hA, rdv, erv);
    #1;
    chk(rq, 1'b1);
    apb(1'b0, 32'h0, 32'h0, rdv, erv);
    chk(rdv, 32'h2);
    $display("reacquire test done");
  endtask

  initial
  begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_eqoff();
    t_clken();
    t_color();
    t_pol();
    t_lock();
    t_reacq();
    finish_test();
  end
endmodule // tb_veq_ctrl
